// [rtl/core_flag_status_register.v]
// core flag and status register bank with an AHB-Lite slave port
// assumes a single AHB-Lite master, word transfers, inputs synchronous
// to hclk; debug, synthesizer, DMA and bit-I/O units sit outside
//
// Function
// RL1 - writing 1 to bit 15 requests low-power standby and 0 means not standby.
// RL2 - reset clears only the standby bit and no other flag bit.
// RL3 - bit 9 is 1 while the debug output buffer holds an untaken word.
// RL4 - bit 8 is 1 while the debug input buffer is empty.
// RL5 - bit 6 is 1 while the clock synthesizer is phase-locked.
// RL6 - a write to the synthesizer config clears the lock flag until relock.
// RL7 - bits 5 and 4 are 1 while DMA channel 1 or 0 has output pending.
// RL8 - the two DMA pending bits ignore software writes.
// RL9 - bit 0 is 1 when all tested inputs match, none are tested or all are outputs.
// RL10 - bit 1 is 1 when no tested input matches, none are tested or all are outputs.
// RL11 - bit 2 is always the inverse of bit 1.
// RL12 - bit 3 is always the inverse of bit 0.
// RL13 - the four bit-I/O flags are recomputed on every clock.
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "core_flag_defs.vh"

module core_flag_status_register #(
	parameter BITIO_WIDTH = 8
) (
	input wire hclk, // bus and core clock
	input wire hresetn, // asynchronous reset, active low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // 1 = write
	input wire [2:0] hsize, // transfer size, word only
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output wire hreadyout, // slave ready
	output wire hresp, // always OKAY
	output wire [31:0] hrdata, // read data
	output wire standby_req, // core standby request level
	input wire wake_event, // pulse: core leaves standby
	input wire debug_out_buffer_full, // debug output word untaken
	input wire debug_in_buffer_empty, // debug input side empty
	input wire debug_continue_flag, // debug continue level
	input wire synth_locked, // synthesizer lock level
	output wire [15:0] synth_config, // synthesizer configuration
	output wire synth_config_wr, // pulse: configuration written
	input wire dma_ch0_output_pending, // channel 0 output busy
	input wire dma_ch1_output_pending, // channel 1 output busy
	input wire [BITIO_WIDTH-1:0] bit_io_port, // bit-I/O pin levels
	input wire [BITIO_WIDTH-1:0] bitio_dir_out, // 1 = pin is output
	output wire [15:0] arith_unit_control_0, // arithmetic control word
	output wire irq // level interrupt
);

	// bus state machine, one-hot
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_WRITE = 4'h2;
	localparam [3:0] ST_RD_WAIT = 4'h4;
	localparam [3:0] ST_RD_DONE = 4'h8;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [7:0] addr_reg;
	reg [7:0] addr_next;
	reg [31:0] hrdata_reg;

	reg standby_reg;
	reg relock_pend_reg;
	reg lock_prev_reg;
	reg [15:0] arith_unit_control_0_reg;
	reg [15:0] synth_cfg_reg;
	reg [15:0] bitio_ctrl_reg;
	reg [3:0] cond_reg;
	reg [3:0] cond_next;
	reg [`IRQ_COUNT-1:0] irq_status_reg;
	reg [`IRQ_COUNT-1:0] irq_status_next;
	reg [`IRQ_COUNT-1:0] irq_enable_reg;
	reg dma0_prev_reg;
	reg dma1_prev_reg;
	reg din_empty_prev_reg;
	reg dout_full_prev_reg;

	wire take;
	wire wr_now;
	wire lock_flag;
	wire all_match;
	wire none_match;
	wire [15:0] flag_word;
	wire [`IRQ_COUNT-1:0] irq_event;
	wire [`IRQ_COUNT-1:0] irq_clear;
	wire wr_flag_word;
	wire wr_synth_cfg;
	wire wr_irq_clear;
	wire lock_rise;
	wire rd_wait;
	reg [31:0] read_mux;

	assign take = hsel & hready & htrans[1];
	assign wr_now = state_reg[1];
	assign rd_wait = state_reg[2];
	// write decodes, valid in the data phase while hwdata stands
	assign wr_flag_word = wr_now && addr_reg == `ADDR_CORE_FLAG_STATUS;
	assign wr_synth_cfg = wr_now && addr_reg == `ADDR_CLK_SYNTH_CONFIG;
	assign wr_irq_clear = wr_now && addr_reg == `ADDR_IRQ_CLEAR;
	assign lock_rise = synth_locked & ~lock_prev_reg;

	// address phase capture; hsize is not checked, word access assumed
	always @* begin
		state_next = state_reg;
		addr_next = addr_reg;
		case (state_reg)
		ST_IDLE, ST_WRITE, ST_RD_DONE: begin
			if (take) begin
				addr_next = haddr[7:0];
				if (hwrite) begin
					state_next = ST_WRITE;
				end else begin
					state_next = ST_RD_WAIT;
				end
			end else begin
				state_next = ST_IDLE;
			end
		end
		// one wait state lets a preceding write settle before the read
		ST_RD_WAIT: begin
			state_next = ST_RD_DONE;
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			addr_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
		end
	end

	// a read answers after one wait state: hreadyout drops for the
	// cycle after the address phase, and hrdata stands from the cycle after that
	assign hreadyout = ~rd_wait;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// bit-I/O conditions: test select and pattern come from the control
	bitio_condition #(
		.WIDTH(BITIO_WIDTH)
	) u_cond (
		.pins_in(bit_io_port),
		.pin_is_output(bitio_dir_out),
		.test_select(bitio_ctrl_reg[`BITIO_TEST_SEL_LSB+:BITIO_WIDTH]),
		.pattern(bitio_ctrl_reg[`BITIO_PATTERN_LSB+:BITIO_WIDTH]),
		.all_match(all_match),
		.none_match(none_match)
	);

	always @* begin
		cond_next = 4'h0;
		cond_next[`BIT_ALL_MATCH] = all_match; // RL9
		cond_next[`BIT_NONE_MATCH] = none_match; // RL10
		cond_next[`BIT_SOME_MATCH] = ~none_match; // RL11
		cond_next[`BIT_SOME_MISMATCH] = ~all_match; // RL12
	end

	// flags follow the pins every clock; no reset so they are never
	// forced by reset, and they are valid one clock after it
	always @(posedge hclk) begin
		cond_reg <= cond_next; // RL13
	end

	// lock reads low from a config write until the synthesizer relocks
	assign lock_flag = synth_locked & ~relock_pend_reg; // RL5

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			relock_pend_reg <= 1'b0;
			// reset high so a synthesizer that stays locked through
			// reset raises no false lock-gained event afterwards
			lock_prev_reg <= 1'b1;
		end else begin
			lock_prev_reg <= synth_locked;
			if (wr_synth_cfg) begin
				relock_pend_reg <= 1'b1; // RL6
			end else if (lock_rise) begin
				relock_pend_reg <= 1'b0; // RL6
			end
		end
	end

	assign synth_config_wr = wr_synth_cfg;
	assign synth_config = synth_cfg_reg;

	// flag word as software sees it; reserved bits read zero
	assign flag_word = {standby_reg, 5'h00,
		debug_out_buffer_full, // RL3
		debug_in_buffer_empty, // RL4
		debug_continue_flag,
		lock_flag,
		dma_ch1_output_pending, // RL7
		dma_ch0_output_pending, // RL7
		cond_reg};

	// standby: software write sets or clears; a wake pulse clears, but a
	// same-cycle software write wins so a standby request is not lost
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			standby_reg <= `RST_STANDBY; // RL2
		end else if (wr_flag_word) begin
			standby_reg <= hwdata[`BIT_STANDBY_REQ]; // RL1
		end else if (wake_event) begin
			standby_reg <= 1'b0;
		end
	end

	assign standby_req = standby_reg; // RL1

	// plain storage registers; a write to the flag word touches only the
	// standby bit, so the DMA pending bits cannot be altered
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arith_unit_control_0_reg <= `RST_ARITH_UNIT_CTRL0;
			synth_cfg_reg <= `RST_CLK_SYNTH_CONFIG;
			bitio_ctrl_reg <= `RST_BITIO_CONTROL;
			irq_enable_reg <= `RST_IRQ;
		end else if (wr_now) begin
			case (addr_reg)
			`ADDR_CORE_FLAG_STATUS: begin
				// pending bits are live inputs with no storage behind them,
				// so a flag-word write reaches only the standby bit
				arith_unit_control_0_reg <= arith_unit_control_0_reg; // RL8
			end
			`ADDR_ARITH_UNIT_CTRL0: begin
				arith_unit_control_0_reg <= hwdata[15:0];
			end
			`ADDR_CLK_SYNTH_CONFIG: begin
				synth_cfg_reg <= hwdata[15:0];
			end
			`ADDR_BITIO_CONTROL: begin
				bitio_ctrl_reg <= hwdata[15:0];
			end
			`ADDR_IRQ_ENABLE: begin
				irq_enable_reg <= hwdata[`IRQ_COUNT-1:0];
			end
			default: begin
				arith_unit_control_0_reg <= arith_unit_control_0_reg; // RL8
			end
			endcase
		end
	end

	assign arith_unit_control_0 = arith_unit_control_0_reg;

	// interrupt events: edges of the reported flags
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dma0_prev_reg <= 1'b0;
			dma1_prev_reg <= 1'b0;
			din_empty_prev_reg <= 1'b0;
			dout_full_prev_reg <= 1'b0;
		end else begin
			dma0_prev_reg <= dma_ch0_output_pending;
			dma1_prev_reg <= dma_ch1_output_pending;
			din_empty_prev_reg <= debug_in_buffer_empty;
			dout_full_prev_reg <= debug_out_buffer_full;
		end
	end

	assign irq_event[`IRQ_LOCK_GAINED] = lock_rise;
	assign irq_event[`IRQ_DMA_CH0_DONE] =
		dma0_prev_reg & ~dma_ch0_output_pending;
	assign irq_event[`IRQ_DMA_CH1_DONE] =
		dma1_prev_reg & ~dma_ch1_output_pending;
	assign irq_event[`IRQ_DEBUG_IN_FILLED] =
		din_empty_prev_reg & ~debug_in_buffer_empty;
	assign irq_event[`IRQ_DEBUG_OUT_DRAINED] =
		dout_full_prev_reg & ~debug_out_buffer_full;

	assign irq_clear = wr_irq_clear ?
		hwdata[`IRQ_COUNT-1:0] : `RST_IRQ;

	// an event in the clearing cycle survives the clear
	always @* begin
		irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_reg <= `RST_IRQ;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	// read mux; the clear register reads zero, unmapped reads zero
	always @* begin
		read_mux = 32'h0000_0000;
		case (addr_reg)
		`ADDR_CORE_FLAG_STATUS: begin
			read_mux[15:0] = flag_word;
		end
		`ADDR_ARITH_UNIT_CTRL0: begin
			read_mux[15:0] = arith_unit_control_0_reg;
		end
		`ADDR_CLK_SYNTH_CONFIG: begin
			read_mux[15:0] = synth_cfg_reg;
		end
		`ADDR_BITIO_CONTROL: begin
			read_mux[15:0] = bitio_ctrl_reg;
		end
		`ADDR_IRQ_STATUS: begin
			read_mux[`IRQ_COUNT-1:0] = irq_status_reg;
		end
		`ADDR_IRQ_CLEAR: begin
			read_mux = 32'h0000_0000;
		end
		`ADDR_IRQ_ENABLE: begin
			read_mux[`IRQ_COUNT-1:0] = irq_enable_reg;
		end
		default: begin
			read_mux = 32'h0000_0000;
		end
		endcase
	end

	// read data is sampled at the end of the wait cycle and then held
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (rd_wait) begin
			hrdata_reg <= read_mux;
		end
	end

endmodule

`default_nettype wire

// [rtl/core_flag_defs.vh]
// constants for the core flag and status register bank
// assumes byte addressing on a 32-bit AHB-Lite bus, one register per word
`ifndef CORE_FLAG_DEFS_VH
`define CORE_FLAG_DEFS_VH

// register byte offsets (low address bits of haddr)
`define ADDR_CORE_FLAG_STATUS 8'h00
`define ADDR_ARITH_UNIT_CTRL0 8'h04
`define ADDR_CLK_SYNTH_CONFIG 8'h08
`define ADDR_BITIO_CONTROL 8'h0C
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_CLEAR 8'h14
`define ADDR_IRQ_ENABLE 8'h18

// core flag and status bit positions
`define BIT_STANDBY_REQ 15
`define BIT_DEBUG_OUT_FULL 9
`define BIT_DEBUG_IN_EMPTY 8
`define BIT_DEBUG_CONTINUE 7
`define BIT_SYNTH_LOCK 6
`define BIT_DMA_CH1_PEND 5
`define BIT_DMA_CH0_PEND 4
`define BIT_SOME_MISMATCH 3
`define BIT_SOME_MATCH 2
`define BIT_NONE_MATCH 1
`define BIT_ALL_MATCH 0

// bit-I/O control fields: pattern [7:0], test select [15:8]
`define BITIO_PATTERN_LSB 0
`define BITIO_TEST_SEL_LSB 8

// interrupt status bit positions
`define IRQ_LOCK_GAINED 0
`define IRQ_DMA_CH0_DONE 1
`define IRQ_DMA_CH1_DONE 2
`define IRQ_DEBUG_IN_FILLED 3
`define IRQ_DEBUG_OUT_DRAINED 4
`define IRQ_COUNT 5

// reset values
`define RST_STANDBY 1'h0
`define RST_ARITH_UNIT_CTRL0 16'h0000
`define RST_CLK_SYNTH_CONFIG 16'h0000
`define RST_BITIO_CONTROL 16'h0000
`define RST_IRQ 5'h00

`endif

// [rtl/bitio_condition.v]
// bit-I/O pattern compare: derives all-match and none-match conditions
// assumes pin, direction and select inputs are synchronous to the clock
`timescale 1ns/10ps
`default_nettype none

module bitio_condition #(
	parameter WIDTH = 8
) (
	input wire [WIDTH-1:0] pins_in, // current pin levels
	input wire [WIDTH-1:0] pin_is_output, // 1 = pin driven as output
	input wire [WIDTH-1:0] test_select, // 1 = pin takes part in test
	input wire [WIDTH-1:0] pattern, // expected levels
	output wire all_match, // every tested input equals pattern
	output wire none_match // no tested input equals pattern
);

	wire [WIDTH-1:0] tested;
	wire [WIDTH-1:0] differs;

	// outputs never count as tested, so all-output gives an empty test set
	assign tested = test_select & ~pin_is_output;
	assign differs = (pins_in ^ pattern) & tested;
	// an empty test set makes both conditions true
	assign all_match = ~|differs; // RL9
	assign none_match = ~|(~(pins_in ^ pattern) & tested); // RL10

endmodule

`default_nettype wire

// [verif/cfsr_asserts.sv]
// checker for the flag register bank: bus timing, standby, lock, flags
// assumes hready is tied to hreadyout and one bus master
`timescale 1ns/10ps
`default_nettype none
module cfsr_asserts (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	input wire logic hreadyout, // slave ready
	input wire logic [31:0] hrdata, // read data
	input wire logic standby_req, // standby level
	input wire logic synth_config_wr, // config strobe
	input wire logic synth_locked, // lock level
	input wire logic dma_ch0_output_pending, // ch0 busy
	input wire logic dma_ch1_output_pending // ch1 busy
);
	logic pw, pr, relock;
	logic [7:0] pa;
	wire logic st = hsel & hready & htrans[1];
	wire logic wd = pr & hreadyout & pa == 8'h00;
	wire logic w0 = pw & hready & pa == 8'h00;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{pw, pr, relock} <= 3'h0;
			pa <= 8'h00;
		end else begin
			if (hready)
				{pw, pr, pa} <= {st & hwrite, st & ~hwrite, haddr[7:0]};
			if (synth_config_wr)
				relock <= 1'b1;
			else if ($rose(synth_locked))
				relock <= 1'b0;
		end
	end
	a_standby_set: assert property (w0 && hwdata[15] |=> standby_req)
		else $error("standby not set");
	a_standby_clear: assert property (w0 && !hwdata[15] |=> !standby_req)
		else $error("standby not cleared");
	a_reset_clear: assert property ($rose(hresetn) |-> !standby_req)
		else $error("standby survives reset");
	a_busy_live: assert property (wd |->
		hrdata[5] == $past(dma_ch1_output_pending) &&
		hrdata[4] == $past(dma_ch0_output_pending))
		else $error("busy bits wrong");
	a_lock_follow: assert property (wd && !relock && !$past(relock)
		|-> hrdata[6] == $past(synth_locked)) else $error("lock bit wrong");
	a_lock_hidden: assert property (wd && relock |-> !hrdata[6])
		else $error("lock shown before relock");
	a_cfg_strobe: assert property (synth_config_wr |-> pw && pa == 8'h08)
		else $error("stray config strobe");
	a_cond_inverse: assert property (wd |-> hrdata[3] != hrdata[0]
		&& hrdata[2] != hrdata[1] && hrdata[31:16] == 16'h0
		&& hrdata[14:10] == 5'h00)
		else $error("condition flags inconsistent");
	a_read_wait: assert property (st && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	c_lock_hidden: cover property (wd && relock);
	c_standby: cover property (w0 && hwdata[15]);
	c_cfg: cover property (synth_config_wr);
endmodule
bind core_flag_status_register cfsr_asserts chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .standby_req(standby_req),
	.synth_config_wr(synth_config_wr), .synth_locked(synth_locked),
	.dma_ch0_output_pending(dma_ch0_output_pending),
	.dma_ch1_output_pending(dma_ch1_output_pending));
`default_nettype wire

// [verif/synth_model.sv]
// synthesizer stand-in: loses lock on each config write, relocks after delay cycles, never if delay is zero
// assumes the config strobe is a one-cycle pulse on hclk
`timescale 1ns/10ps
`default_nettype none
module synth_model (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic cfg_wr, // config strobe
	input wire logic [7:0] delay, // cycles to relock
	output logic locked // lock level
);
	logic [7:0] cnt;
	// locked out of reset, as a free-running synthesizer would be
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			locked <= 1'b1;
			cnt <= 8'h00;
		end else if (cfg_wr) begin
			locked <= 1'b0;
			cnt <= delay;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			locked <= cnt == 8'h01;
		end
	end
endmodule
`default_nettype wire

// [verif/core_flag_status_register_test.sv]
// self-checking bench for the core flag and status register bank
// assumes the bench is the only bus master; lock comes from synth_model
`timescale 1ns/10ps
`default_nettype none
module core_flag_status_register_test;
	logic hclk, hresetn, hsel, hwrite, wake_event, dbo, dbi, dma0, dma1, dcf;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, q;
	logic [7:0] pins, dir, lk_delay;
	wire logic hready, hresp, standby_req, synth_config_wr, irq, locked;
	wire logic [31:0] hrdata;
	wire logic [15:0] synth_config, auc;
	int errors, comparisons;
	core_flag_status_register dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .standby_req(standby_req),
		.wake_event(wake_event), .debug_out_buffer_full(dbo),
		.debug_in_buffer_empty(dbi), .debug_continue_flag(dcf),
		.synth_locked(locked), .synth_config(synth_config),
		.synth_config_wr(synth_config_wr), .dma_ch0_output_pending(dma0),
		.dma_ch1_output_pending(dma1), .bit_io_port(pins),
		.bitio_dir_out(dir), .arith_unit_control_0(auc), .irq(irq));
	synth_model pll (.hclk(hclk), .hresetn(hresetn),
		.cfg_wr(synth_config_wr), .delay(lk_delay), .locked(locked));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task chk(input string n, input logic [31:0] s, e);
		begin
			comparisons++;
			if (s !== e) begin
				errors++;
				$display("BAD %s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d errors %0d", comparisons, errors);
			if (errors == 0 && comparisons > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task rdy;
		int n;
		begin
			@(posedge hclk);
			for (n = 0; hready !== 1'b1; n++) begin
				if (n == 20) begin
					errors++;
					tally_and_finish;
				end
				@(posedge hclk);
			end
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			hsel <= 1'b1;
			hwrite <= w;
			htrans <= 2'h2;
			haddr <= {24'h0, a};
			rdy;
			htrans <= 2'h0;
			hwdata <= d;
			rdy;
			q = hrdata;
		end
	endtask
	task do_reset;
		begin
			hresetn <= 1'b0;
			repeat (5) @(posedge hclk);
			hresetn <= 1'b1;
		end
	endtask
	// flag bits {3,2,1,0}: some differ, some match, none match, all match
	function logic [3:0] ef(input logic [7:0] p, d, s, t);
		logic [7:0] u, m;
		begin
			u = s & ~d;
			m = ~(p ^ t) & u;
			ef = {m != u, m != 8'h00, m == 8'h00, m == u};
		end
	endfunction
	task t_standby;
		begin
			xfer(0, 8'h00, 32'h0);
			chk("flags", q, 32'h0000_0143);
			xfer(1, 8'h00, 32'h0000_8030);
			xfer(0, 8'h00, 32'h0);
			chk("flags", q, 32'h0000_8143);
			xfer(1, 8'h00, 32'h0);
			@(posedge hclk);
			chk("standby", 32'(standby_req), 32'h0);
			xfer(1, 8'h00, 32'h0000_8000);
			wake_event <= 1'b1;
			@(posedge hclk);
			wake_event <= 1'b0;
			@(posedge hclk);
			chk("wake", 32'(standby_req), 32'h0);
			xfer(1, 8'h00, 32'h0000_8000);
			do_reset;
			xfer(0, 8'h00, 32'h0);
			chk("flags", q, 32'h0000_0143);
			$display("standby test done");
		end
	endtask
	task t_live;
		begin
			{dcf, dbo, dbi, dma1, dma0} <= 5'h1A;
			xfer(0, 8'h00, 32'h0);
			chk("live", q & 32'h0000_03F0, 32'h0000_02E0);
			{dcf, dbo, dbi, dma1, dma0} <= 5'h05;
			xfer(0, 8'h00, 32'h0);
			chk("live", q & 32'h0000_03F0, 32'h0000_0150);
			dma0 <= 1'b0;
			$display("live flag test done");
		end
	endtask
	task t_lock;
		begin
			lk_delay <= 8'h14;
			xfer(1, 8'h08, 32'h0000_1234);
			@(posedge hclk);
			chk("cfg", 32'(synth_config), 32'h0000_1234);
			xfer(0, 8'h00, 32'h0);
			chk("lock", q & 32'h40, 32'h0);
			repeat (30) @(posedge hclk);
			xfer(0, 8'h00, 32'h0);
			chk("lock", q & 32'h40, 32'h40);
			lk_delay <= 8'h01;
			xfer(1, 8'h08, 32'h0000_0055);
			repeat (3) @(posedge hclk);
			xfer(0, 8'h00, 32'h0);
			chk("lock", q & 32'h40, 32'h40);
			$display("lock test done");
		end
	endtask
	task bcase(input logic [7:0] p, d, s, t);
		begin
			pins <= p;
			dir <= d;
			xfer(1, 8'h0C, {16'h0, s, t});
			xfer(0, 8'h00, 32'h0);
			chk("cond", 32'(q[3:0]), 32'(ef(p, d, s, t)));
		end
	endtask
	task t_bitio;
		begin
			bcase(8'hA5, 8'h00, 8'h00, 8'h00);
			bcase(8'hA5, 8'hFF, 8'hFF, 8'h00);
			bcase(8'hA5, 8'h00, 8'hFF, 8'hA5);
			bcase(8'h5A, 8'h00, 8'hFF, 8'hA5);
			bcase(8'hA5, 8'h00, 8'h0F, 8'hA0);
			bcase(8'hA5, 8'h0F, 8'hFF, 8'hA0);
			$display("bit-io test done");
		end
	endtask
	task t_irq;
		begin
			xfer(1, 8'h14, 32'h1F);
			xfer(1, 8'h18, 32'h02);
			xfer(0, 8'h10, 32'h0);
			chk("status", q, 32'h0);
			dma0 <= 1'b1;
			@(posedge hclk);
			dma0 <= 1'b0;
			repeat (3) @(posedge hclk);
			chk("irq", 32'(irq), 32'h1);
			xfer(0, 8'h10, 32'h0);
			chk("status", q, 32'h02);
			xfer(1, 8'h14, 32'h02);
			@(posedge hclk);
			chk("irq", 32'(irq), 32'h0);
			xfer(1, 8'h18, 32'h0);
			dma1 <= 1'b1;
			@(posedge hclk);
			dma1 <= 1'b0;
			repeat (3) @(posedge hclk);
			xfer(0, 8'h10, 32'h0);
			chk("status", q, 32'h04);
			chk("masked", 32'(irq), 32'h0);
			xfer(1, 8'h04, 32'h0000_A5C3);
			xfer(1, 8'h1C, 32'hFFFF_FFFF);
			xfer(0, 8'h04, 32'h0);
			chk("auc", q, 32'h0000_A5C3);
			chk("auc port", 32'(auc), 32'h0000_A5C3);
			xfer(0, 8'h1C, 32'h0);
			chk("unmapped", q, 32'h0);
			chk("hresp", 32'(hresp), 32'h0);
			$display("irq and register test done");
		end
	endtask
	initial begin
		{hsel, hwrite, wake_event, dbo, dma0, dma1, hresetn, dcf} = 8'h00;
		{htrans, haddr, hwdata, pins, dir} = 82'h0;
		{dbi, lk_delay} = 9'h101;
		{errors, comparisons} = 64'h0;
		do_reset;
		t_standby;
		t_live;
		t_lock;
		t_bitio;
		t_irq;
		tally_and_finish;
	end
endmodule
`default_nettype wire
